// file: src/ssc_pkg.sv
// package for the sram sleep-mode controller
// assumes a single 100 MHz device clock; no registers reached by software
package ssc_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned SLEEP_ENTRY_CYCLES = 2;  // entry delay, clocks
    localparam int unsigned SLEEP_WAKE_CYCLES = 2;   // wake-up delay, clocks
    localparam int unsigned SLEEP_RECOVERY_NS = 20;  // recovery interval, ns
    localparam int unsigned SLEEP_RECOVERY_CYCLES =
        (SLEEP_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 2;

    // ------------------------------------------------------------
    // data path widths and reset values
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 18;
    localparam int unsigned DATA_W = 18;
    localparam int unsigned BE_W = 2;
    localparam int unsigned DEPTH = 1 << ADDR_W;
    localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;

    // ------------------------------------------------------------
    // power states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SSC_ACTIVE   = 2'b00,
        SSC_ENTERING = 2'b01,
        SSC_ASLEEP   = 2'b10,
        SSC_WAKING   = 2'b11
    } ssc_pwr_t;

endpackage : ssc_pkg

// file: src/ssc_sleep_fsm.sv
// sleep entry / wake sequencer
// assumes sleep_request is already synchronised to ref_clk
module ssc_sleep_fsm (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // request and status
    input wire logic sleep_req_s,
    output logic asleep,
    output logic waking,
    output ssc_pkg::ssc_pwr_t state
);
    ssc_pkg::ssc_pwr_t state_q, state_d;
    logic [ssc_pkg::CNT_W-1:0] cnt_q, cnt_d;
    localparam logic [ssc_pkg::CNT_W-1:0] ENTRY_LAST =
        ssc_pkg::CNT_W'(ssc_pkg::SLEEP_ENTRY_CYCLES - 1);
    localparam logic [ssc_pkg::CNT_W-1:0] WAKE_LAST =
        ssc_pkg::CNT_W'(ssc_pkg::SLEEP_WAKE_CYCLES - 1);

    // next state: delays counted from the first edge the new level is seen
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            ssc_pkg::SSC_ACTIVE: begin
                cnt_d = '0;
                if (sleep_req_s) state_d = ssc_pkg::SSC_ENTERING;
            end
            ssc_pkg::SSC_ENTERING: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == ENTRY_LAST) begin
                    state_d = ssc_pkg::SSC_ASLEEP;
                    cnt_d = '0;
                end
            end
            ssc_pkg::SSC_ASLEEP: begin
                cnt_d = '0;
                if (!sleep_req_s) state_d = ssc_pkg::SSC_WAKING;
            end
            ssc_pkg::SSC_WAKING: begin
                cnt_d = cnt_q + 1'b1;
                if (sleep_req_s) begin
                    state_d = ssc_pkg::SSC_ASLEEP;
                    cnt_d = '0;
                end else if (cnt_q == WAKE_LAST) begin
                    state_d = ssc_pkg::SSC_ACTIVE;
                    cnt_d = '0;
                end
            end
            default: begin
                state_d = ssc_pkg::SSC_ACTIVE;
                cnt_d = '0;
            end
        endcase
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= ssc_pkg::SSC_ACTIVE;
            cnt_q <= '0;
        end else if (clk_en) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    assign asleep = (state_q == ssc_pkg::SSC_ASLEEP);
    assign waking = (state_q == ssc_pkg::SSC_WAKING);
    assign state = state_q;
endmodule : ssc_sleep_fsm

// file: src/ssc_sram_sleep.sv
// sram core with sleep-mode control and selectable read pipeline
// assumes synchronous command inputs; no software registers
// ------------------------------------------------------------
// Summary of operation
// - sleep is entered two clocks after the request is seen high.
// - memory, burst and pipeline context are held through sleep.
// - normal commands resume two clocks after the request is seen low.
// - asleep means deselected, inputs ignored, data bus released.
// - once entry starts, sleep is always reached; it lasts until the request is seen low.
// - request is asynchronous, active high; its assertion alone starts sleep.
// - a mode input picks flow-through or pipelined reads.
// - flow-through: address on first edge, write data at second edge.
// ------------------------------------------------------------
module ssc_sram_sleep (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // power control
    input wire logic sleep_request,
    input wire logic flow_through_select,
    // command
    input wire logic sel,
    input wire logic we,
    input wire logic adv,
    input wire logic [ssc_pkg::BE_W-1:0] be,
    input wire logic [ssc_pkg::ADDR_W-1:0] addr,
    // data bus, three signals
    input wire logic [ssc_pkg::DATA_W-1:0] dq_in,
    output logic [ssc_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe_n,
    // status
    output logic sleep_active,
    output logic recovering,
    output logic write_in_recovery
);
    // ------------------------------------------------------------
    // request synchroniser
    // ------------------------------------------------------------
    logic req_meta_q, req_sync_q;

    // two-flop catcher for the asynchronous request; only the second flop
    // is read, so a metastable first stage never reaches the sequencer
    // and the entry and wake delays count from the settled level
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            req_meta_q <= 1'b0;
            req_sync_q <= 1'b0;
        end else if (clk_en) begin
            req_meta_q <= sleep_request;
            req_sync_q <= req_meta_q;
        end
    end

    logic asleep, waking;
    ssc_pkg::ssc_pwr_t pwr_state;

    ssc_sleep_fsm u_fsm (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .sleep_req_s(req_sync_q),
        .asleep(asleep),
        .waking(waking),
        .state(pwr_state)
    );

    // ------------------------------------------------------------
    // command gating
    // ------------------------------------------------------------
    logic live;
    // only the active and entering phases take commands; asleep and waking
    // look like a deselect, so nothing the controller sends can move state
    assign live = clk_en && ((pwr_state == ssc_pkg::SSC_ACTIVE) ||
                             (pwr_state == ssc_pkg::SSC_ENTERING));

    localparam int unsigned LANE_W = ssc_pkg::DATA_W / ssc_pkg::BE_W;

    logic [ssc_pkg::ADDR_W-1:0] base_q, cur_addr;
    logic [1:0] burst_q;
    logic [1:0] burst_off;
    logic wr_pend_q, wr_pend2_q;
    logic [ssc_pkg::ADDR_W-1:0] wa_q, wa2_q;
    logic [ssc_pkg::BE_W-1:0] wbe_q, wbe2_q;
    logic wr_fire;
    logic [ssc_pkg::ADDR_W-1:0] wr_addr;
    logic [ssc_pkg::BE_W-1:0] wr_lane;
    logic rd_q, rd2_q;
    logic [ssc_pkg::DATA_W-1:0] rd_word;
    logic [ssc_pkg::DATA_W-1:0] rdat_q, pipe_q;

    // linear burst: low two bits step from the loaded base and wrap after four
    assign burst_off = base_q[1:0] + burst_q + 2'h1;
    assign cur_addr = adv ? {base_q[ssc_pkg::ADDR_W-1:2], burst_off} : addr;

    // burst counter; held while asleep
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            base_q <= '0;
            burst_q <= 2'h0;
        end else if (live && sel) begin
            if (adv) begin
                burst_q <= burst_q + 2'h1;
            end else begin
                base_q <= addr;
                burst_q <= 2'h0;
            end
        end
    end

    // first write stage: address and lanes taken with the command
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wr_pend_q <= 1'b0;
            wa_q <= '0;
            wbe_q <= '0;
        end else if (live) begin
            wr_pend_q <= sel && we && (be != '0); // all lanes off is a write abort
            wa_q <= cur_addr;
            wbe_q <= be;
        end
    end

    // second write stage: only the pipelined mode waits for it
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wr_pend2_q <= 1'b0;
            wa2_q <= '0;
            wbe2_q <= '0;
        end else if (live) begin
            wr_pend2_q <= wr_pend_q;
            wa2_q <= wa_q;
            wbe2_q <= wbe_q;
        end
    end

    // pick the stage whose data stands on dq_in at this edge
    always_comb begin
        if (flow_through_select) begin
            wr_fire = wr_pend_q;
            wr_addr = wa_q;
            wr_lane = wbe_q;
        end else begin
            wr_fire = wr_pend2_q;
            wr_addr = wa2_q;
            wr_lane = wbe2_q;
        end
    end

    // ------------------------------------------------------------
    // byte lanes
    // ------------------------------------------------------------
    // each lane keeps its own array, so a masked lane is never rewritten
    for (genvar g = 0; g < ssc_pkg::BE_W; g++) begin : g_lane
        logic [LANE_W-1:0] lane_mem [ssc_pkg::DEPTH];

        // lane write; frozen while asleep or waking so contents survive
        always_ff @(posedge ref_clk) begin
            if (live && wr_fire && wr_lane[g]) begin
                lane_mem[wr_addr] <= dq_in[g*LANE_W +: LANE_W];
            end
        end

        // array read for this lane
        assign rd_word[g*LANE_W +: LANE_W] = lane_mem[cur_addr];
    end

    // read qualifier stages follow the command while state is live
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rd_q <= 1'b0;
            rd2_q <= 1'b0;
        end else if (live) begin
            rd_q <= sel && !we;
            rd2_q <= rd_q;
        end
    end

    // array output register; the flow-through bus reads this one
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdat_q <= ssc_pkg::DATA_RST;
        end else if (live) begin
            rdat_q <= rd_word;
        end
    end

    // extra output register, used only by the pipelined mode
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pipe_q <= ssc_pkg::DATA_RST;
        end else if (live) begin
            pipe_q <= rdat_q;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign dq_out = flow_through_select ? rdat_q : pipe_q;
    // bus released whenever asleep or waking, or when no read is due
    assign dq_oe_n = asleep || waking ||
                     !(flow_through_select ? rd_q : rd2_q);
    // status follows the power state flops
    assign sleep_active = asleep;
    assign recovering = waking;
    // a write while recovering is dropped; the flag lets the controller see it
    assign write_in_recovery = waking && sel && we;
endmodule : ssc_sram_sleep

// file: tb/ssc_sram_sleep_chk.sv
// checker for the sram sleep block, bound to its ports
// assumes one clock and a synchronous active-low reset
module ssc_sram_sleep_chk (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // commands and power control
    input wire logic sleep_request,
    input wire logic flow_through_select,
    input wire logic sel,
    input wire logic we,
    // status and bus
    input wire logic dq_oe_n,
    input wire logic sleep_active,
    input wire logic recovering,
    input wire logic write_in_recovery
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // power state timing
    chk_sleep_bus_off: assert property (sleep_active |-> dq_oe_n)
        else $error("bus driven while asleep");
    chk_entry_not_early: assert property ($rose(sleep_request) && !recovering
        && !sleep_active |-> !sleep_active[*3]) else $error("sleep entered early");
    chk_entry_done: assert property (sleep_request[*6] |-> sleep_active)
        else $error("sleep not entered");
    chk_stay_asleep: assert property (sleep_request[*3] ##0 sleep_active |=> sleep_active)
        else $error("sleep ended early");
    chk_wake_start: assert property (!sleep_request[*3] ##0 sleep_active |-> ##[1:2] recovering)
        else $error("wake not started");
    chk_wake_len: assert property ($rose(recovering) && !sleep_request |->
        recovering[*2] ##1 !recovering) else $error("wake length wrong");

    // commands around recovery and read latency
    chk_rec_flag: assert property (clk_en && recovering && sel && we |-> write_in_recovery)
        else $error("write in recovery not flagged");
    chk_flag_idle: assert property (!recovering |-> !write_in_recovery)
        else $error("recovery flag outside recovery");
    chk_ft_read: assert property (!sleep_request[*3] ##0 (clk_en && sel && !we
        && flow_through_select && !sleep_active && !recovering) |=> !dq_oe_n)
        else $error("flow-through read not driven");
    chk_pipe_read: assert property (!sleep_request[*3] ##0 (clk_en && sel && !we
        && !flow_through_select && !sleep_active && !recovering) |-> ##2 !dq_oe_n)
        else $error("pipelined read not driven");
endmodule : ssc_sram_sleep_chk

bind ssc_sram_sleep ssc_sram_sleep_chk chk_i (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .sleep_request(sleep_request),
    .flow_through_select(flow_through_select),
    .sel(sel),
    .we(we),
    .dq_oe_n(dq_oe_n),
    .sleep_active(sleep_active),
    .recovering(recovering),
    .write_in_recovery(write_in_recovery)
);

// file: tb/ssc_ctrl_model.sv
// memory controller model that drives commands and the sleep request
// assumes the bench never runs two cmd calls at once; slp may run beside one
module ssc_ctrl_model (
    // clock
    input wire logic ref_clk,
    // read bus
    input wire logic [ssc_pkg::DATA_W-1:0] dq_out,
    input wire logic dq_oe_n,
    // commands and power control
    output logic sleep_request = 1'b0, // low in normal operation
    output logic flow_through_select = 1'b1,
    output logic sel = 1'b0,
    output logic we = 1'b0,
    output logic [ssc_pkg::ADDR_W-1:0] addr = 18'h00000,
    output logic [ssc_pkg::DATA_W-1:0] dq_in = 18'h00000
);
    timeunit 1ns;
    timeprecision 1ps;

    // one command; write data at the late-write edge of the mode
    task automatic cmd(input logic ft, input logic w, input logic [ssc_pkg::ADDR_W-1:0] a,
        input logic [ssc_pkg::DATA_W-1:0] d, output logic [ssc_pkg::DATA_W-1:0] q);
        @(posedge ref_clk);
        flow_through_select <= ft;
        sel <= 1'b1;
        we <= w;
        addr <= a;
        dq_in <= ~dq_in; // stale data is never left on the bus
        @(posedge ref_clk);
        sel <= 1'b0;
        if (!ft) @(posedge ref_clk);
        dq_in <= d;
        @(negedge ref_clk);
        q = dq_oe_n ? ~dq_out : dq_out; // a released bus reads back inverted
    endtask : cmd

    // sleep for n clocks; only called with no command in flight
    task automatic slp(input int n);
        @(posedge ref_clk);
        sleep_request <= 1'b1;
        repeat (n) @(posedge ref_clk);
        sleep_request <= 1'b0;
    endtask : slp
endmodule : ssc_ctrl_model

// file: tb/ssc_sram_sleep_tb.sv
// self-checking bench for the sram sleep block
// assumes the controller model drives commands and the checker is bound
module ssc_sram_sleep_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic ft; logic w; logic [17:0] a; logic [17:0] d;} ssc_row_t;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic adv = 1'b0;
    logic [1:0] be = 2'h3;
    logic sleep_request, flow_through_select, sel, we, dq_oe_n;
    logic sleep_active, recovering, write_in_recovery;
    logic [17:0] addr, dq_in, dq_out, q;
    int n_errors = 0;
    int cmp_count = 0;
    ssc_row_t rows[6] = '{'{1'h1, 1'h1, 18'h00005, 18'h2a5a5},
        '{1'h1, 1'h0, 18'h00005, 18'h2a5a5}, '{1'h0, 1'h1, 18'h3ffff, 18'h15a5a},
        '{1'h0, 1'h0, 18'h3ffff, 18'h15a5a}, '{1'h1, 1'h0, 18'h3ffff, 18'h15a5a},
        '{1'h0, 1'h0, 18'h00005, 18'h2a5a5}};

    // clock
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    ssc_sram_sleep dut (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .sleep_request(sleep_request),
        .flow_through_select(flow_through_select),
        .sel(sel),
        .we(we),
        .adv(adv),
        .be(be),
        .addr(addr),
        .dq_in(dq_in),
        .dq_out(dq_out),
        .dq_oe_n(dq_oe_n),
        .sleep_active(sleep_active),
        .recovering(recovering),
        .write_in_recovery(write_in_recovery)
    );
    ssc_ctrl_model ctl (
        .ref_clk(ref_clk),
        .dq_out(dq_out),
        .dq_oe_n(dq_oe_n),
        .sleep_request(sleep_request),
        .flow_through_select(flow_through_select),
        .sel(sel),
        .we(we),
        .addr(addr),
        .dq_in(dq_in)
    );

    // compare and count
    task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] s);
        cmp_count++;
        if (s !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    // bounded wait for a status level
    task automatic wait_for(ref logic s, input logic v);
        int i;
        for (i = 0; i < 40 && s !== v; i++) @(negedge ref_clk);
        if (i == 40) begin
            n_errors++;
            give_verdict();
        end
    endtask : wait_for

    // report and end the run
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict

    // main sequence
    initial begin
        repeat (4) @(negedge ref_clk);
        chk("rst_bus_off", 18'h1, {17'h0, dq_oe_n});
        chk("rst_awake", 18'h0, {17'h0, sleep_active});
        @(posedge ref_clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            ctl.cmd(rows[i].ft, rows[i].w, rows[i].a, rows[i].d, q);
            if (!rows[i].w) chk("read", rows[i].d, q);
        end
        // sleep with an ignored write, then a write during recovery
        fork
            ctl.slp(12);
            begin
                repeat (7) @(negedge ref_clk);
                chk("asleep", 18'h1, {17'h0, sleep_active});
                chk("bus_off", 18'h1, {17'h0, dq_oe_n});
                ctl.cmd(1'b1, 1'b1, 18'h00005, 18'h00000, q);
            end
        join
        wait_for(recovering, 1'b1);
        ctl.cmd(1'b1, 1'b1, 18'h3ffff, 18'h00000, q);
        wait_for(recovering, 1'b0);
        ctl.cmd(1'b1, 1'b0, 18'h00005, 18'h00000, q);
        chk("kept", 18'h2a5a5, q);
        ctl.cmd(1'b0, 1'b0, 18'h3ffff, 18'h00000, q);
        chk("dropped", 18'h15a5a, q);
        // burst base loaded before a sleep must still step after wake-up
        ctl.cmd(1'b1, 1'b0, 18'h00004, 18'h00000, q);
        ctl.slp(12);
        wait_for(recovering, 1'b1);
        wait_for(recovering, 1'b0);
        @(posedge ref_clk);
        adv <= 1'b1;
        ctl.cmd(1'b1, 1'b0, 18'h3ffff, 18'h00000, q);
        chk("burst_kept", 18'h2a5a5, q);
        @(posedge ref_clk);
        adv <= 1'b0;
        give_verdict();
    end
endmodule : ssc_sram_sleep_tb
